/* include/sad_pkg.sv */
// slot address decode: shared constants, carrier structs and state codes
// assumes a single 25 MHz board clock and a synchronous active-low reset
package sad_pkg;

  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int SAD_CLK_NS      = 40;
  // settle time for the pulled-up slot lines after reset release
  localparam int SAD_SETTLE_NS   = 1000;
  localparam int SAD_SETTLE_CYC  =
    (SAD_SETTLE_NS + SAD_CLK_NS - 1) / SAD_CLK_NS;
  localparam int SAD_CNT_W       = 5;
  localparam logic [SAD_CNT_W-1:0] SAD_SETTLE_LAST =
    SAD_CNT_W'(SAD_SETTLE_CYC - 1);

  // -------------------------------------------------------------------
  // address layout and fixed values
  // -------------------------------------------------------------------
  localparam logic [4:0] SAD_AMNESIA_SLOT = 5'h1e;
  localparam int SAD_BAR_HI  = 7;
  localparam int SAD_BAR_LO  = 3;
  localparam int SAD_ADDR_HI = 23;
  localparam int SAD_ADDR_LO = 19;
  localparam logic [2:0] SAD_BAR_LOW_BITS = 3'h0;

  // reset values of the synchroniser stages: lines idle pulled high
  localparam logic [4:0] SAD_GA_RST   = 5'h1f;
  localparam logic       SAD_GAP_RST  = 1'b1;
  localparam logic [7:0] SAD_MODE_RST = 8'h00;

  // -------------------------------------------------------------------
  // carriers
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [4:0] ga_n;   // slot address lines, active low
    logic       gap_n;  // slot parity line, active low
  } sad_pins_s;

  typedef struct packed {
    logic       par_chk_en;    // act on slot parity
    logic       bad_par_mute;  // on bad parity ignore config space
    logic       legacy_sw_en;  // allow local switch fallback
    logic [4:0] sw_slot;       // local switch / jumper slot value
  } sad_mode_s;

  typedef struct packed {
    logic [7:0] bar;      // base address register value
    logic [4:0] slot;     // decoded slot number in use
    logic       par_err;  // sampled slot parity was bad
    logic       amnesia;  // amnesia address substituted
    logic       from_sw;  // slot taken from local switches
    logic       mute;     // config space accesses ignored
    logic       ready;    // sampling done, decode live
  } sad_stat_s;

  typedef enum logic [2:0] {
    SAD_SETTLE = 3'b001,
    SAD_LATCH  = 3'b010,
    SAD_RUN    = 3'b100
  } sad_state_e;

endpackage

/* logic/sad_sync.sv */
// two-flop synchroniser for a bundle of slow static pins
// assumes pins change rarely; bits are not guaranteed coherent mid-change
`timescale 1ns/1ps
`default_nettype none
module sad_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sad_sync_s;

  sad_sync_s st_r;
  sad_sync_s st_nxt;

  // first stage feeds only the second
  always_comb
  begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st_r <= '{s1: RST, s2: RST};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;

endmodule
`default_nettype wire

/* logic/sad_core.sv */
// slot address decode: samples slot lines once after reset, forms the
// config-space base address and decodes config-space hits
// assumes cfg_req/cfg_addr come from logic on core_clk, pins are async
//
// What this block does
// - base address comes from slot address pins
// - base bits 7..3 match address 23..19
// - config space sits at slot-derived location
// - bad parity substitutes amnesia address 30
// - parity check may be switched off
// - bad parity may instead mute config space
// - no grounded line: use local switch value
// - pulled-up lines are inverted to slot number
// - all lines open flags parity error; slot 0 with switch fallback off, unless parity check is on with mute off
`timescale 1ns/1ps
`default_nettype none
module sad_core (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire sad_pkg::sad_pins_s   pins,
  input  wire sad_pkg::sad_mode_s   mode,
  input  wire logic                 cfg_req,
  input  wire logic [23:0]          cfg_addr,
  output sad_pkg::sad_stat_s        stat,
  output logic                      cfg_hit
);

  // -------------------------------------------------------------------
  // synchronisers
  // -------------------------------------------------------------------
  localparam int SYNC_W = $bits(sad_pkg::sad_pins_s)
                        + $bits(sad_pkg::sad_mode_s);

  sad_pkg::sad_pins_s pin_s;
  sad_pkg::sad_mode_s mode_s;

  // mode straps are board pins too, so they share the synchroniser
  sad_sync #(
    .W   (SYNC_W),
    .RST ({sad_pkg::SAD_GA_RST, sad_pkg::SAD_GAP_RST,
           sad_pkg::SAD_MODE_RST})
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .d        ({pins, mode}),
    .q        ({pin_s, mode_s})
  );

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  typedef struct packed {
    sad_pkg::sad_state_e              st;
    logic [sad_pkg::SAD_CNT_W-1:0]    cnt;
    sad_pkg::sad_stat_s               stat;
    logic                             hit;
  } sad_core_s;

  localparam sad_core_s CORE_RST = '{
    st:   sad_pkg::SAD_SETTLE,
    cnt:  '0,
    stat: '0,
    hit:  1'b0
  };

  sad_core_s q_r;
  sad_core_s q_nxt;

  logic [4:0] slot_pin;
  logic       par_bad;
  logic       none_gnd;
  logic       use_sw;
  logic       addr_match;

  // pin interpretation, used only in the latch state; address compare used in run
  assign slot_pin   = ~pin_s.ga_n;
  assign par_bad    = ~(^{pin_s.ga_n, pin_s.gap_n});
  assign none_gnd   = &pin_s.ga_n;
  assign use_sw     = mode_s.legacy_sw_en & none_gnd;
  assign addr_match = cfg_addr[sad_pkg::SAD_ADDR_HI:sad_pkg::SAD_ADDR_LO]
                   == q_r.stat.bar[sad_pkg::SAD_BAR_HI:sad_pkg::SAD_BAR_LO];

  // settle, take one sample, then decode forever
  always_comb
  begin
    q_nxt     = q_r;
    q_nxt.hit = 1'b0;
    case (q_r.st)
      sad_pkg::SAD_SETTLE:
      begin
        // lines need time to pull up after power-up reset
        if (q_r.cnt == sad_pkg::SAD_SETTLE_LAST)
        begin
          q_nxt.st = sad_pkg::SAD_LATCH;
        end
        else
        begin
          q_nxt.cnt = q_r.cnt + 1'b1;
        end
      end
      sad_pkg::SAD_LATCH:
      begin
        // parity flag reported even when not acted on
        q_nxt.stat.par_err = par_bad;
        q_nxt.stat.amnesia = 1'b0;
        q_nxt.stat.mute    = 1'b0;
        q_nxt.stat.from_sw = 1'b0;
        if (use_sw)
        begin
          // legacy backplane: local switches win
          q_nxt.stat.slot    = mode_s.sw_slot;
          q_nxt.stat.from_sw = 1'b1;
        end
        else if (mode_s.par_chk_en && par_bad)
        begin
          if (mode_s.bad_par_mute)
          begin
            q_nxt.stat.slot = slot_pin;
            q_nxt.stat.mute = 1'b1;
          end
          else
          begin
            q_nxt.stat.slot    = sad_pkg::SAD_AMNESIA_SLOT;
            q_nxt.stat.amnesia = 1'b1;
          end
        end
        else
        begin
          q_nxt.stat.slot = slot_pin;
        end
        q_nxt.stat.bar   = {q_nxt.stat.slot,
                            sad_pkg::SAD_BAR_LOW_BITS};
        q_nxt.stat.ready = 1'b1;
        q_nxt.st         = sad_pkg::SAD_RUN;
      end
      sad_pkg::SAD_RUN:
      begin
        // a board answering at slot 30 lets the monarch recover it
        q_nxt.hit = cfg_req & ~q_r.stat.mute & addr_match;
      end
      default:
      begin
        q_nxt = CORE_RST;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      q_r <= CORE_RST;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  assign stat    = q_r.stat;
  assign cfg_hit = q_r.hit;

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  logic       in_latch;
  logic       in_settle;
  logic [4:0] addr_top;
  assign in_latch  = (q_r.st == sad_pkg::SAD_LATCH);
  assign in_settle = (q_r.st == sad_pkg::SAD_SETTLE);
  assign addr_top  = cfg_addr[23:19];

  a_slot_inverted: assert property (
    (in_latch && !use_sw && !(mode_s.par_chk_en && par_bad))
    |=> (stat.slot == ~$past(pin_s.ga_n)) && !stat.amnesia)
    else $error("slot not inverted pin value");

  a_amnesia_sub: assert property (
    (in_latch && !use_sw && mode_s.par_chk_en && par_bad
     && !mode_s.bad_par_mute)
    |=> stat.amnesia && stat.slot == 5'h1e && stat.bar == 8'hf0)
    else $error("amnesia address not substituted");

  a_mute_on_bad: assert property (
    (in_latch && !use_sw && mode_s.par_chk_en && par_bad
     && mode_s.bad_par_mute)
    |=> stat.mute && !stat.amnesia)
    else $error("bad parity did not mute");

  a_mute_no_hit: assert property (
    stat.mute |-> ##1 !cfg_hit)
    else $error("muted board answered");

  a_nocheck_raw: assert property (
    (in_latch && !use_sw && !mode_s.par_chk_en)
    |=> stat.slot == $past(slot_pin) && !stat.mute)
    else $error("unchecked slot not used directly");

  a_legacy_switch: assert property (
    (in_latch && use_sw)
    |=> stat.from_sw && stat.slot == $past(mode_s.sw_slot))
    else $error("switch fallback not taken");

  a_legacy_perr: assert property (
    (in_latch && pin_s == 6'h3f) |=> stat.par_err)
    else $error("open lines did not flag parity");

  a_odd_parity: assert property (
    in_latch |=> stat.par_err == ~(^$past(pin_s)))
    else $error("parity not odd over six lines");

  a_latch_once: assert property (
    stat.ready |=> $stable(stat))
    else $error("sample changed after latch");

  a_bar_layout: assert property (
    $rose(stat.ready) |-> stat.bar[7:3] == stat.slot
      && stat.bar[2:0] == 3'h0 && $past(in_settle, 2))
    else $error("base address layout wrong");

  a_hit_decode: assert property (
    (q_r.st == sad_pkg::SAD_RUN && cfg_req && !stat.mute
     && addr_top == stat.bar[7:3]) |=> cfg_hit)
    else $error("config access not decoded");

  a_hit_cause: assert property (
    cfg_hit |-> $past(cfg_req)
      && $past(addr_top) == stat.bar[7:3])
    else $error("hit without matching access");

  c_amnesia: cover property ($rose(stat.amnesia));
  c_mute:    cover property ($rose(stat.mute));
  c_switch:  cover property ($rose(stat.from_sw));
  c_hit:     cover property (cfg_hit);

endmodule
`default_nettype wire

/* verif/sad_monarch.sv */
// monarch model: probes all 32 config slots, counts the answers
// assumes cfg_hit pulses one cycle after a taken request
`timescale 1ns/1ps
`default_nettype none
module sad_monarch (
  input  wire logic   core_clk,
  input  wire logic   start,
  input  wire logic   cfg_hit,
  output logic        cfg_req,
  output logic [23:0] cfg_addr,
  output logic        done,
  output logic [5:0]  n_hit,
  output logic [4:0]  hit_slot
);
  logic [5:0] idx;
  logic [1:0] ph;

  // probe, release, look; slower than needed so stray hits stand out
  always @(posedge core_clk)
  begin
    if (!start)
    begin
      cfg_req  <= #1 1'b0;
      cfg_addr <= #1 24'h000000;
      idx   <= 6'h00;
      ph    <= 2'h0;
      done  <= 1'b0;
      n_hit <= 6'h00;
    end
    else if (!done)
    begin
      ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      if (ph == 2'h0)
      begin
        cfg_req  <= #1 1'b1;
        cfg_addr <= #1 {idx[4:0], 19'h2a5a5};
      end
      else if (ph == 2'h1)
      begin
        cfg_req  <= #1 1'b0;
        cfg_addr <= #1 ~cfg_addr;  // released bus shows no stale address
      end
      else
      begin
        if (cfg_hit === 1'b1)
        begin
          n_hit    <= n_hit + 6'h01;
          hit_slot <= idx[4:0];  // slot 30 is probed as well
        end
        idx  <= idx + 6'h01;
        done <= (idx == 6'h1f);
      end
    end
  end
endmodule
`default_nettype wire

/* verif/slot_address_base_decode_tb.sv */
// self-checking bench for the slot address decode core
// assumes straps are static and a monarch model scans config space
`timescale 1ns/1ps
`default_nettype none
module slot_address_base_decode_tb;
  logic               core_clk;
  logic               rst_n;
  sad_pkg::sad_pins_s pins;
  sad_pkg::sad_mode_s mode;
  logic               cfg_req;
  logic [23:0]        cfg_addr;
  sad_pkg::sad_stat_s stat;
  logic               cfg_hit;
  logic               start;
  logic               done;
  logic [5:0]         n_hit;
  logic [4:0]         hit_slot;
  int                 mismatches;
  int                 n_checks;

  sad_core i_sad_core (
    .core_clk(core_clk), .rst_n(rst_n), .pins(pins), .mode(mode),
    .cfg_req(cfg_req), .cfg_addr(cfg_addr), .stat(stat),
    .cfg_hit(cfg_hit));

  sad_monarch i_sad_monarch (
    .core_clk(core_clk), .start(start), .cfg_hit(cfg_hit),
    .cfg_req(cfg_req), .cfg_addr(cfg_addr), .done(done),
    .n_hit(n_hit), .hit_slot(hit_slot));

  // 25 MHz board clock
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic fail(string msg);
    mismatches++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask

  // compares: status word, then the monarch's scan result
  task automatic chk_stat(sad_pkg::sad_stat_s exp);
    n_checks++;
    if (stat !== exp)
      fail($sformatf("stat %h expected %h", stat, exp));
  endtask

  task automatic chk_scan(logic [5:0] n, logic [4:0] s);
    n_checks++;
    if (n_hit !== n || (n != 6'h00 && hit_slot !== s))
      fail($sformatf("scan %0d hits at slot %0d", n_hit, hit_slot));
  endtask

  // flags f = {par_err, amnesia, from_sw, mute}
  function automatic sad_pkg::sad_stat_s mk(logic [4:0] s, logic [3:0] f);
    return {s, 3'h0, s, f, 1'b1};
  endfunction

  // reset with given straps, bounded wait for ready
  task automatic boot(logic [4:0] ga_n, logic gap_n, sad_pkg::sad_mode_s m);
    int i;
    @(posedge core_clk);
    #1;
    rst_n = 1'b0;
    pins  = {ga_n, gap_n};
    mode  = m;
    repeat (10) @(posedge core_clk);
    #1;
    chk_stat('0);
    rst_n = 1'b1;
    for (i = 0; i < 100 && stat.ready !== 1'b1; i++)
    begin
      @(posedge core_clk);
      #1;
    end
    if (i == 100)
    begin
      fail("ready never rose");
      results();
    end
  endtask

  // monarch walks every slot; bounded wait for its end
  task automatic scan(logic [5:0] n, logic [4:0] s);
    int i;
    start = 1'b1;
    for (i = 0; i < 200 && done !== 1'b1; i++)
    begin
      @(posedge core_clk);
      #1;
    end
    if (i == 200)
    begin
      fail("scan never finished");
      results();
    end
    start = 1'b0;
    chk_scan(n, s);
  endtask

  // grounded line and good parity: switch and mute fallbacks armed, none taken
  task automatic t_good_slot();
    boot(5'h1a, 1'b0, 8'hec);
    chk_stat(mk(5'h05, 4'h0));
    pins = 6'h3f;
    scan(6'h01, 5'h05);
  endtask

  task automatic t_amnesia();
    boot(5'h18, 1'b0, 8'h80);
    chk_stat(mk(5'h1e, 4'hc));
    scan(6'h01, 5'h1e);
  endtask

  task automatic t_no_check();
    boot(5'h18, 1'b0, 8'h00);
    chk_stat(mk(5'h07, 4'h8));
    scan(6'h01, 5'h07);
  endtask

  task automatic t_mute();
    boot(5'h18, 1'b0, 8'hc0);
    chk_stat(mk(5'h07, 4'h9));
    scan(6'h00, 5'h00);
  endtask

  task automatic t_legacy();
    boot(5'h1f, 1'b1, 8'hac);
    chk_stat(mk(5'h0c, 4'ha));
    scan(6'h01, 5'h0c);
  endtask

  task automatic t_open();
    boot(5'h1f, 1'b1, 8'h00);
    chk_stat(mk(5'h00, 4'h8));
    scan(6'h01, 5'h00);
  endtask

  initial
  begin
    mismatches = 0;
    n_checks   = 0;
    rst_n      = 1'b0;
    pins       = 6'h3f;
    mode       = 8'h00;
    start      = 1'b0;
    t_good_slot();
    t_amnesia();
    t_no_check();
    t_mute();
    t_legacy();
    t_open();
    results();
  end
endmodule
`default_nettype wire
